// ===== common/ahc_defs.svh
// Constants of the AHB controller: map, decode windows and record layout
`ifndef AHC_DEFS_SVH
`define AHC_DEFS_SVH
`define AHC_NM 4
`define AHC_NS 3
`define AHC_NP 2
`define AHC_IO_AREA 12'hFFF
`define AHC_PNP_AREA 8'hFF
`define AHC_APB_PNP 8'hFF
`define AHC_BRG_BASE 12'h800
`define AHC_BRG_MASK 12'hFFF
`define AHC_S_BASE {12'hFFF, 12'h400, 12'h000}
`define AHC_S_MASK {12'hFFF, 12'hFFF, 12'hE00}
`define AHC_S_IO 3'b100
`define AHC_P_BASE {12'h001, 12'h000}
`define AHC_P_MASK {12'hFFF, 12'hFFF}
`define AHC_M_ID 32'h0001_0000
`define AHC_S_ID 32'h0002_0000
`define AHC_P_ID 32'h0003_0000
`define AHC_BAR_MEM 4'h2
`define AHC_BAR_IO 4'h3
`define AHC_BAR_APB 4'h1
`endif

// ===== common/ahc_pkg.sv
// Types of the AHB controller
package ahc_pkg;
  typedef enum logic [1:0] {
    TR_IDLE = 2'h0,
    TR_BUSY = 2'h1,
    TR_NONSEQ = 2'h2,
    TR_SEQ = 2'h3
  } ahc_trans_t;
  typedef enum logic [1:0] {
    RSP_OKAY = 2'h0,
    RSP_ERROR = 2'h1
  } ahc_resp_t;
  typedef enum {
    BR_IDLE,
    BR_CAPT,
    BR_SETUP,
    BR_ACCESS
  } ahc_brg_state_t;
endpackage : ahc_pkg

// ===== design/ahc_ctrl.sv
// AHB arbiter, bus multiplexer, slave decoder, record area and APB bridge
// Overview of operation
// - Rotate priority one step per completed transfer
// - No request: keep granting last owner
// - Memory slaves in aligned 1M..2048M windows
// - I/O area at 0xFFF00000, 256B..512K windows
// - Unclaimed address gets AHB ERROR response
// - Read-only record area 0xFFFFF000..0xFFFFFFFF
// - Master records low half, slaves from 0xFFFFF800
// - 32-byte records, 64 masters, 64 slaves
// - Bridge is APB master, aligned 256B..512K slaves
// - Bridge records in top 4 kbytes
// - 8-byte APB records at bridge plus 0xFF000
`include "ahc_defs.svh"
module ahc_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`AHC_NM-1:0] hbusreqM,
  input wire logic [`AHC_NM-1:0][1:0] htransM,
  input wire logic [`AHC_NM-1:0][31:0] haddrM,
  input wire logic [`AHC_NM-1:0] hwriteM,
  input wire logic [`AHC_NM-1:0][2:0] hsizeM,
  input wire logic [`AHC_NM-1:0][31:0] hwdataM,
  output logic [`AHC_NM-1:0] hgrantM,
  output logic [1:0] hmaster,
  output logic hready,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  output logic [`AHC_NS-1:0] hselS,
  output logic [31:0] haddrS,
  output logic [1:0] htransS,
  output logic hwriteS,
  output logic [2:0] hsizeS,
  output logic [31:0] hwdataS,
  input wire logic [`AHC_NS-1:0] hreadyoutS,
  input wire logic [`AHC_NS-1:0][1:0] hrespS,
  input wire logic [`AHC_NS-1:0][31:0] hrdataS,
  output logic [`AHC_NP-1:0] psel,
  output logic penable,
  output logic pwrite,
  output logic [19:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [`AHC_NP-1:0][31:0] prdata
);
  localparam logic [`AHC_NS*12-1:0] SBASE = `AHC_S_BASE;
  localparam logic [`AHC_NS*12-1:0] SMASK = `AHC_S_MASK;
  localparam logic [`AHC_NS-1:0] SIO = `AHC_S_IO;
  localparam logic [`AHC_NP*12-1:0] PBASE = `AHC_P_BASE;
  localparam logic [`AHC_NP*12-1:0] PMASK = `AHC_P_MASK;

  // Aligned window match: masked address bits equal masked base
  function automatic logic winHit(input logic [11:0] a, input logic [11:0] base,
                                  input logic [11:0] mask);
    winHit = (mask != 12'h000) && ((a & mask) == (base & mask));
  endfunction : winHit

  function automatic logic [31:0] barWord(input logic [11:0] base,
                                          input logic [11:0] mask, input logic [3:0] kind);
    barWord = {base, 4'h0, mask, kind};
  endfunction : barWord

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rstMeta_reg;
  logic rstSync_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  wire rstInt_n = rstSync_reg;

  // ************************************************************
  // Arbitration
  // ************************************************************
  logic [1:0] prio_reg;
  logic [1:0] owner_reg;
  logic [1:0] nextOwner;
  logic found;
  logic [1:0] cand;
  always_comb begin
    nextOwner = owner_reg;
    found = 1'b0;
    cand = 2'h0;
    for (int k = 0; k < `AHC_NM; k++) begin
      cand = prio_reg + 2'(k);
      if (!found && hbusreqM[cand]) begin
        nextOwner = cand;
        found = 1'b1;
      end
    end
  end

  // ************************************************************
  // Address phase decode
  // ************************************************************
  wire [31:0] aAddr = haddrM[hmaster];
  wire [1:0] aTrans = htransM[hmaster];
  wire aReq = aTrans[1];
  wire inIo = (aAddr[31:20] == `AHC_IO_AREA);
  wire inPnp = inIo && (aAddr[19:12] == `AHC_PNP_AREA);
  wire [`AHC_NS-1:0] sHit;
  wire [`AHC_NP-1:0] pHit;
  genvar g;
  generate
    for (g = 0; g < `AHC_NS; g++) begin : gSlave
      assign sHit[g] = !inPnp && (SIO[g] ? (inIo && winHit(aAddr[19:8],
                       SBASE[g*12 +: 12], SMASK[g*12 +: 12]))
                       : (!inIo && winHit(aAddr[31:20], SBASE[g*12 +: 12],
                       SMASK[g*12 +: 12])));
    end
    for (g = 0; g < `AHC_NP; g++) begin : gApb
      assign pHit[g] = winHit(aAddr[19:8], PBASE[g*12 +: 12], PMASK[g*12 +: 12]);
    end
  endgenerate
  wire brgHit = !inIo && winHit(aAddr[31:20], `AHC_BRG_BASE, `AHC_BRG_MASK);
  wire brgPnp = brgHit && (aAddr[19:12] == `AHC_APB_PNP);
  wire brgApb = brgHit && !brgPnp && (pHit != '0);
  wire extHit = (sHit != '0) && !brgHit;
  wire anyHit = extHit || inPnp || brgPnp || brgApb;
  logic [1:0] sIdx;
  logic pIdx;
  always_comb begin
    sIdx = 2'h0;
    pIdx = 1'b0;
    for (int i = `AHC_NS - 1; i >= 0; i--) begin
      if (sHit[i]) sIdx = 2'(i);
    end
    for (int i = `AHC_NP - 1; i >= 0; i--) begin
      if (pHit[i]) pIdx = 1'(i);
    end
  end

  // Record contents; slots past the populated ones stay zero
  logic [31:0] pnpWord;
  wire [5:0] recIdx = aAddr[10:5];
  wire [2:0] recWord = aAddr[4:2];
  wire [8:0] apbIdx = aAddr[11:3];
  always_comb begin
    pnpWord = 32'h0000_0000;
    if (inPnp && !aAddr[11]) begin
      if (recIdx < 6'(`AHC_NM) && recWord == 3'h0) pnpWord = `AHC_M_ID | 32'(recIdx);
    end else if (inPnp) begin
      if (recIdx < 6'(`AHC_NS) && recWord == 3'h0) pnpWord = `AHC_S_ID | 32'(recIdx);
      if (recIdx < 6'(`AHC_NS) && recWord == 3'h4) begin
        pnpWord = barWord(SBASE[recIdx[1:0]*12 +: 12], SMASK[recIdx[1:0]*12 +: 12],
                          SIO[recIdx[1:0]] ? `AHC_BAR_IO : `AHC_BAR_MEM);
      end
      if (recIdx == 6'(`AHC_NS) && recWord == 3'h0) pnpWord = `AHC_S_ID | 32'(recIdx);
      if (recIdx == 6'(`AHC_NS) && recWord == 3'h4) begin
        pnpWord = barWord(`AHC_BRG_BASE, `AHC_BRG_MASK, `AHC_BAR_MEM);
      end
    end else if (brgPnp && apbIdx < 9'(`AHC_NP)) begin
      if (!aAddr[2]) pnpWord = `AHC_P_ID | 32'(apbIdx);
      else pnpWord = barWord(PBASE[apbIdx[0]*12 +: 12], PMASK[apbIdx[0]*12 +: 12],
                             `AHC_BAR_APB);
    end
  end

  // ************************************************************
  // Data phase tracking and default slave
  // ************************************************************
  logic dExt_reg;
  logic dPnp_reg;
  logic dApb_reg;
  logic dErr_reg;
  logic errSecond_reg;
  logic [1:0] dSel_reg;
  logic [1:0] dMaster_reg;
  logic [31:0] pnpData_reg;
  ahc_pkg::ahc_brg_state_t brgState_reg;
  ahc_pkg::ahc_brg_state_t brgState_next;
  wire errFirst = dErr_reg && !errSecond_reg;
  wire busReady = dExt_reg ? hreadyoutS[dSel_reg] : dApb_reg ?
                  (brgState_reg == ahc_pkg::BR_ACCESS) : !errFirst;
  wire accept = busReady && aReq;
  wire done = busReady && (dExt_reg || dPnp_reg || dApb_reg || dErr_reg);
  wire pnpWrite = (inPnp || brgPnp) && hwriteM[hmaster];

  always_ff @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      prio_reg <= 2'h0;
      owner_reg <= 2'h0;
      hmaster <= 2'h0;
      hgrantM <= `AHC_NM'(1);
    end else begin
      if (done) prio_reg <= prio_reg + 2'h1;
      owner_reg <= nextOwner;
      hgrantM <= `AHC_NM'(1) << nextOwner;
      if (busReady) hmaster <= owner_reg;
    end
  end

  always_ff @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      dExt_reg <= 1'b0;
      dPnp_reg <= 1'b0;
      dApb_reg <= 1'b0;
      dErr_reg <= 1'b0;
      errSecond_reg <= 1'b0;
      dSel_reg <= 2'h0;
      dMaster_reg <= 2'h0;
      pnpData_reg <= 32'h0000_0000;
    end else begin
      errSecond_reg <= errFirst;
      if (busReady) begin
        dExt_reg <= accept && extHit;
        dPnp_reg <= accept && (inPnp || brgPnp) && !pnpWrite;
        dApb_reg <= accept && brgApb && !inPnp;
        dErr_reg <= accept && (!anyHit || pnpWrite);
        dSel_reg <= sIdx;
        dMaster_reg <= hmaster;
        pnpData_reg <= pnpWord;
      end
    end
  end

  // ************************************************************
  // APB bridge
  // ************************************************************
  logic pIdx_reg;
  always_comb begin
    brgState_next = brgState_reg;
    case (brgState_reg)
      ahc_pkg::BR_IDLE: if (accept && brgApb && !inPnp) brgState_next = ahc_pkg::BR_CAPT;
      ahc_pkg::BR_CAPT: brgState_next = ahc_pkg::BR_SETUP;
      ahc_pkg::BR_SETUP: brgState_next = ahc_pkg::BR_ACCESS;
      // A new APB access may be accepted in the last cycle of the current one
      ahc_pkg::BR_ACCESS: brgState_next = (accept && brgApb && !inPnp) ? ahc_pkg::BR_CAPT :
                                          ahc_pkg::BR_IDLE;
      default: brgState_next = ahc_pkg::BR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      brgState_reg <= ahc_pkg::BR_IDLE;
      pIdx_reg <= 1'b0;
      paddr <= 20'h00000;
      pwrite <= 1'b0;
      pwdata <= 32'h0000_0000;
      psel <= '0;
      penable <= 1'b0;
    end else begin
      brgState_reg <= brgState_next;
      if (brgState_next == ahc_pkg::BR_CAPT) begin
        paddr <= aAddr[19:0];
        pwrite <= hwriteM[hmaster];
        pIdx_reg <= pIdx;
      end
      if (brgState_reg == ahc_pkg::BR_CAPT) begin
        pwdata <= hwdataM[dMaster_reg];
        psel <= `AHC_NP'(1) << pIdx_reg;
      end
      penable <= (brgState_reg == ahc_pkg::BR_SETUP);
      if (brgState_reg == ahc_pkg::BR_ACCESS) psel <= '0;
    end
  end

  // ************************************************************
  // Bus multiplexing
  // ************************************************************
  // Slave-side signals are muxed without a register to keep zero-wait transfers
  assign hselS = (aReq && extHit) ? sHit : '0;
  assign haddrS = aAddr;
  assign htransS = aTrans;
  assign hwriteS = hwriteM[hmaster];
  assign hsizeS = hsizeM[hmaster];
  assign hwdataS = hwdataM[dMaster_reg];
  assign hready = busReady;
  assign hresp = dErr_reg ? ahc_pkg::RSP_ERROR : dExt_reg ? hrespS[dSel_reg] :
                 ahc_pkg::RSP_OKAY;
  assign hrdata = dExt_reg ? hrdataS[dSel_reg] : dApb_reg ? prdata[pIdx_reg] :
                  dPnp_reg ? pnpData_reg : 32'h0000_0000;
endmodule : ahc_ctrl

// ===== verif/ahc_ctrl_sva.sv
// Port checker of the AHB controller
module ahc_ctrl_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] hbusreqM,
  input wire logic [3:0] hgrantM,
  input wire logic [1:0] hmaster,
  input wire logic hready,
  input wire logic [1:0] hresp,
  input wire logic [2:0] hselS,
  input wire logic [31:0] haddrS,
  input wire logic [1:0] htransS,
  input wire logic hwriteS,
  input wire logic [1:0] psel,
  input wire logic penable,
  input wire logic [19:0] paddr
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [1:0] gIdx;
  logic aPh;
  logic rec;
  assign gIdx = {hgrantM[3] | hgrantM[2], hgrantM[3] | hgrantM[1]};
  assign aPh = hready && htransS[1];
  assign rec = haddrS[31:12] == 20'hFFFFF;
  sequence apbSetup;
    (|psel) && !penable;
  endsequence
  sequence apbAccess;
    (|psel) && penable;
  endsequence
  chk_grant_onehot: assert property ($onehot(hgrantM))
    else $error("grant not one-hot");
  chk_grant_req: assert property (hready && |hbusreqM |=> |(hgrantM & $past(hbusreqM)))
    else $error("grant went to a master without request");
  chk_owner_follow: assert property (hready |=> hmaster == $past(gIdx))
    else $error("bus owner does not follow grant");
  chk_park_keep: assert property ((hbusreqM == 4'h0)[*3] |-> $stable(hgrantM))
    else $error("grant moved while no master requested");
  chk_err_two: assert property (hresp == 2'h1 && !hready |=> hresp == 2'h1 && hready)
    else $error("error response not two cycles");
  chk_unmap_err: assert property (aPh && haddrS[31:28] == 4'h2 |=> hresp == 2'h1 && !hready)
    else $error("unclaimed address not refused");
  chk_mem_sel: assert property (htransS[1] && haddrS[31:20] == 12'h400 |-> hselS == 3'b010)
    else $error("memory slave not selected");
  chk_rec_read: assert property (aPh && rec && !hwriteS |=> hready && hresp == 2'h0)
    else $error("record read not zero wait okay");
  chk_rec_ro: assert property (aPh && rec && hwriteS |=> hresp == 2'h1)
    else $error("record write not refused");
  chk_apb_seq: assert property ($rose(|psel) |-> apbSetup ##1 apbAccess ##[1:2] (psel == 2'b00 && !penable))
    else $error("APB setup access order broken");
  chk_apb_dec: assert property (|psel |-> psel == (paddr[19:8] == 12'h001 ? 2'b10 : 2'b01))
    else $error("APB slave select wrong");
endmodule : ahc_ctrl_chk
bind ahc_ctrl ahc_ctrl_chk chk (.clk, .rst_n, .hbusreqM, .hgrantM, .hmaster, .hready, .hresp,
  .hselS, .haddrS, .htransS, .hwriteS, .psel, .penable, .paddr);

// ===== verif/ahc_far.sv
// Far side model: three AHB slaves, one with a wait state, and two APB slaves
module ahc_far (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] hselS,
  input wire logic [31:0] haddrS,
  input wire logic [1:0] htransS,
  input wire logic hready,
  input wire logic [1:0] psel,
  input wire logic [19:0] paddr,
  output logic [2:0] hreadyoutS,
  output logic [2:0][1:0] hrespS,
  output logic [2:0][31:0] hrdataS,
  output logic [1:0][31:0] prdata
);
  logic [2:0] dSel_reg;
  logic [31:0] dAddr_reg;
  logic wait_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dSel_reg <= 3'h0;
      dAddr_reg <= 32'h0;
      wait_reg <= 1'b0;
    end else if (hready) begin
      dSel_reg <= hselS & {3{htransS[1]}};
      dAddr_reg <= haddrS;
      wait_reg <= hselS[1] & htransS[1];
    end else begin
      wait_reg <= 1'b0;
    end
  end
  assign hreadyoutS = {1'b1, ~wait_reg, 1'b1};
  assign hrespS = '0;
  // Selected AHB slaves and unselected APB slaves show the inverse of the address so a wrong mux pick is seen
  for (genvar i = 0; i < 3; i++) begin : gAhb
    assign hrdataS[i] = dSel_reg[i] ? ~dAddr_reg : dAddr_reg;
  end
  for (genvar i = 0; i < 2; i++) begin : gApb
    assign prdata[i] = psel[i] ? {12'hA5A, paddr} : ~{12'hA5A, paddr};
  end
endmodule : ahc_far

// ===== verif/tb_top.sv
// Testbench of the AHB controller
`include "ahc_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0;
  logic [3:0] hbusreqM = 0, hwriteM = 0;
  logic [3:0][1:0] htransM = '0;
  logic [3:0][31:0] haddrM = '0, hwdataM = '0;
  logic [3:0][2:0] hsizeM = {4{3'h2}};
  wire [3:0] hgrantM;
  wire [1:0] hmaster, hresp, htransS, psel;
  wire hready, hwriteS, penable, pwrite;
  wire [31:0] hrdata, haddrS, hwdataS, pwdata;
  wire [2:0] hselS, hsizeS, hreadyoutS;
  wire [2:0][1:0] hrespS;
  wire [2:0][31:0] hrdataS;
  wire [19:0] paddr;
  wire [1:0][31:0] prdata;
  int bad_count = 0, compares = 0;
  ahc_ctrl uut (.clk, .rst_n, .hbusreqM, .htransM, .haddrM, .hwriteM, .hsizeM, .hwdataM,
    .hgrantM, .hmaster, .hready, .hresp, .hrdata, .hselS, .haddrS, .htransS, .hwriteS,
    .hsizeS, .hwdataS, .hreadyoutS, .hrespS, .hrdataS, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata);
  ahc_far far (.clk, .rst_n, .hselS, .haddrS, .htransS, .hready, .psel, .paddr,
    .hreadyoutS, .hrespS, .hrdataS, .prdata);
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One single transfer of master 0, judged at the end of its address and data phases
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] ed,
                      input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    htransM[0] = 2'h2;
    haddrM[0] = a;
    hwriteM[0] = w;
    do @(negedge clk); while (hready !== 1'b1 && ++n < 20);
    chk("hwriteS", 32'(hwriteS), 32'(w));
    chk("hsizeS", 32'(hsizeS), 32'h2);
    @(posedge clk);
    #1;
    htransM[0] = 2'h0;
    hwdataM[0] = ~a;
    do @(negedge clk); while (hready !== 1'b1 && ++n < 40);
    chk("hresp", 32'(hresp), 32'(er));
    if (w) chk("hwdataS", hwdataS, ~a);
    if (!w && er == 2'h0) chk("hrdata", hrdata, ed);
  endtask : xfer
  task automatic t_reset;
    chk("grant", 32'(hgrantM), 32'h1);
    chk("psel", 32'(psel), 32'h0);
  endtask : t_reset
  task automatic t_rec;
    logic [31:0] ad[10] = '{32'hFFFFF000, 32'hFFFFF020, 32'hFFFFF7E0, 32'hFFFFF800,
      32'hFFFFF830, 32'hFFFFF860, 32'hFFFFFFE0, 32'h800FF000, 32'h800FF00C, 32'h800FF010};
    logic [31:0] ex[10] = '{`AHC_M_ID, `AHC_M_ID | 1, 32'h0, `AHC_S_ID, 32'h4000FFF2,
      `AHC_S_ID | 3, 32'h0, `AHC_P_ID, 32'h0010FFF1, 32'h0};
    foreach (ad[i]) xfer(ad[i], 1'b0, ex[i], 2'h0);
    xfer(32'h800FF008, 1'b0, `AHC_P_ID | 1, 2'h0);
    xfer(32'hFFFFF000, 1'b1, 32'h0, 2'h1);
  endtask : t_rec
  task automatic t_dec;
    xfer(32'h1FFFFFFC, 1'b0, 32'hE0000003, 2'h0);
    xfer(32'h40000010, 1'b0, 32'hBFFFFFEF, 2'h0);
    xfer(32'h20000000, 1'b0, 32'h0, 2'h1);
    xfer(32'h40100000, 1'b0, 32'h0, 2'h1);
    xfer(32'hFFF00000, 1'b0, 32'h0, 2'h1);
  endtask : t_dec
  task automatic t_apb;
    xfer(32'h80000004, 1'b0, 32'hA5A00004, 2'h0);
    xfer(32'h80000104, 1'b0, 32'hA5A00104, 2'h0);
    xfer(32'h80000008, 1'b1, 32'h0, 2'h0);
    chk("pwrite", 32'(pwrite), 32'h1);
    chk("pwdata", pwdata, 32'h7FFFFFF7);
    chk("paddr", 32'(paddr), 32'h00008);
    xfer(32'h80000200, 1'b0, 32'h0, 2'h1);
  endtask : t_apb
  task automatic t_arb;
    logic [3:0] seen, g;
    seen = 4'h0;
    @(posedge clk);
    #1;
    for (int i = 0; i < 4; i++) begin
      htransM[i] = 2'h2;
      haddrM[i] = 32'hFFFFF000;
    end
    hbusreqM = 4'hF;
    repeat (16) begin
      @(negedge clk);
      seen |= hgrantM;
    end
    chk("grants", 32'(seen), 32'hF);
    @(posedge clk);
    #1;
    htransM = '0;
    hbusreqM = 4'h0;
    repeat (3) @(negedge clk);
    g = hgrantM;
    repeat (5) @(negedge clk);
    chk("park", 32'(hgrantM), 32'(g));
    chk("owner", 32'(hgrantM), 32'(4'h1 << hmaster));
  endtask : t_arb
  task automatic finish_test;
    $display("Checks %0d, errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1;
    repeat (3) @(posedge clk);
    t_reset();
    t_rec();
    t_dec();
    t_apb();
    t_arb();
    finish_test();
  end
endmodule : tb_top
